//--- jdm_pkg.sv
// Shared constants, types and helpers of the trouble-code manager.
// Assumes one 10 MHz system clock and APB register access.
package jdm_pkg;
    // Clock rate and time figures.
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned STARTUP_S = 5;
    localparam int unsigned REPEAT_MS = 1000;
    localparam int unsigned MS_CYC_DEF = CLK_HZ / 1000;
    localparam int unsigned STARTUP_CYC_DEF = STARTUP_S * CLK_HZ;
    localparam int unsigned REPEAT_CYC_DEF = REPEAT_MS * MS_CYC_DEF;
    localparam int unsigned CNT_W = 26;

    // Sizes of the definition table.
    localparam int unsigned NDEF = 16;
    localparam int unsigned IDX_W = 4;
    localparam int unsigned SPN_W = 19;
    localparam int unsigned FMI_W = 5;
    localparam int unsigned OC_W = 7;
    localparam int unsigned TMR_W = 16;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATE = 8'h04;
    localparam logic [7:0] OFS_INFO = 8'h08;
    localparam logic [7:0] OFS_SEL = 8'h0c;
    localparam logic [7:0] OFS_CFG = 8'h10;
    localparam logic [7:0] OFS_DELAY = 8'h14;
    localparam logic [7:0] OFS_OC = 8'h18;

    // Field positions.
    localparam int unsigned CTRL_DM11_BIT = 0;
    localparam int unsigned CTRL_DM3_BIT = 1;
    localparam int unsigned CTRL_DM2_BIT = 2;
    localparam int unsigned CFG_FMI_LSB = 19;
    localparam int unsigned CFG_OVR_BIT = 24;
    localparam int unsigned CFG_LAMP_LSB = 25;
    localparam int unsigned CFG_LATCH_BIT = 27;
    localparam int unsigned DLY_FMI_LSB = 16;
    localparam int unsigned INFO_DONE_BIT = 8;
    localparam int unsigned INFO_BUSY_BIT = 9;

    // Values after reset.
    localparam logic [SPN_W-1:0] SPN_RST = 19'h00000;
    localparam logic [FMI_W-1:0] FMI_RST = 5'h1f;
    localparam logic [1:0] LAMP_RST = 2'h1;
    localparam logic [TMR_W-1:0] DELAY_RST = 16'h0064;

    // Codes.
    localparam logic [FMI_W-1:0] FMI_MAX_STD = 5'h15;
    localparam logic [FMI_W-1:0] FMI_EXISTS = 5'h1f;
    localparam logic [OC_W-1:0] OC_MAX = 7'h7e;
    localparam logic [1:0] KIND_DM1 = 2'h1;
    localparam logic [1:0] KIND_DM2 = 2'h2;
    localparam logic [7:0] FLASH_OFF = 8'hff;

    typedef enum {ST_IDLE, ST_HEAD, ST_FETCH, ST_LOAD, ST_SEND}
        jdm_tx_state_t;

    // Lamp byte: two bits per lamp, value 01 means on.
    function automatic logic [7:0] lamp_byte(input logic [1:0] sel);
        lamp_byte = 8'h01 << {sel, 1'b0};
    endfunction : lamp_byte

    // Four-byte trouble code, conversion method bit always zero.
    function automatic logic [31:0] make_dtc(
        input logic [SPN_W-1:0] spn,
        input logic [FMI_W-1:0] fmi,
        input logic [OC_W-1:0] oc);
        make_dtc = {1'b0, oc, spn[18:16], fmi, spn[15:0]};
    endfunction : make_dtc

    function automatic logic fmi_ok(input logic [FMI_W-1:0] f);
        fmi_ok = (f <= FMI_MAX_STD) || (f == FMI_EXISTS);
    endfunction : fmi_ok

    function automatic logic [4:0] popcount(input logic [15:0] m);
        popcount = 5'h00;
        for (int k = 0; k < 16; k++) begin
            popcount = popcount + {4'h0, m[k]};
        end
    endfunction : popcount

    function automatic logic [15:0] onehot(input logic [3:0] i);
        onehot = 16'h0001 << i;
    endfunction : onehot
endpackage : jdm_pkg

//--- jdm_oc_store.sv
// Occurrence count store, one count per definition.
// Counts are kept in an array with no reset so they outlive a reset.
module jdm_oc_store
    import jdm_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Update masks.
    input wire logic [NDEF-1:0] inc_mask,
    input wire logic [NDEF-1:0] clr_mask,
    // Read ports, data one cycle after the index.
    input wire logic [IDX_W-1:0] rd_a_idx,
    output logic [OC_W-1:0] rd_a_data,
    input wire logic [IDX_W-1:0] rd_b_idx,
    output logic [OC_W-1:0] rd_b_data
);
    logic [OC_W-1:0] oc_mem [NDEF];

    // Clear beats increment; counts saturate below the not-available code.
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < NDEF; i++) begin
            if (clr_mask[i]) begin
                oc_mem[i] <= '0;
            end else if (inc_mask[i] && oc_mem[i] < OC_MAX) begin
                oc_mem[i] <= oc_mem[i] + 7'h01;
            end
        end
    end

    // Registered read data.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_a_data <= '0;
            rd_b_data <= '0;
        end else begin
            rd_a_data <= oc_mem[rd_a_idx];
            rd_b_data <= oc_mem[rd_b_idx];
        end
    end
endmodule : jdm_oc_store

//--- jdm_dtc_manager.sv
// Trouble-code manager: sixteen fault definitions, debounce timers,
// active and previously-active state, and DM1/DM2 message streaming.
// Assumes fault inputs come from logic on ref_clk and that a CAN
// transport layer drains the message stream.
module jdm_dtc_manager
    import jdm_pkg::*;
#(
    parameter int unsigned MS_CYC = MS_CYC_DEF,
    parameter int unsigned STARTUP_CYC = STARTUP_CYC_DEF,
    parameter int unsigned REPEAT_CYC = REPEAT_CYC_DEF
)
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // APB slave.
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fault monitors, one level per definition.
    input wire logic [NDEF-1:0] fault_in,
    // Message stream to the transport layer.
    output logic tx_valid,
    input wire logic tx_ready,
    output logic tx_first,
    output logic tx_last,
    output logic [1:0] tx_kind,
    output logic tx_multi,
    output logic [31:0] tx_data
);
    // Configuration per definition.
    logic [SPN_W-1:0] spn_r [NDEF];
    logic [FMI_W-1:0] fmi_r [NDEF];
    logic [FMI_W-1:0] dfmi_r [NDEF];
    logic [TMR_W-1:0] dly_r [NDEF];
    logic [1:0] lamp_r [NDEF];
    logic [NDEF-1:0] ovr_r;
    logic [NDEF-1:0] latch_r;
    logic [IDX_W-1:0] sel_r;
    // Fault state per definition.
    logic [TMR_W-1:0] tmr_r [NDEF];
    logic [NDEF-1:0] pend_r;
    logic [NDEF-1:0] act_r;
    logic [NDEF-1:0] prev_r;
    logic [NDEF-1:0] rep_q_r;
    // Timing.
    logic [CNT_W-1:0] ms_cnt_r;
    logic [CNT_W-1:0] up_cnt_r;
    logic [CNT_W-1:0] rep_cnt_r;
    logic ms_tick;
    logic up_done_r;
    logic rep_tick;
    // Requests and pending messages.
    logic dm1_pend_r;
    logic dm2_pend_r;
    // Sender.
    jdm_tx_state_t st_r;
    logic [NDEF-1:0] list_r;
    logic [IDX_W-1:0] scan_r;
    logic [1:0] kind_r;
    logic multi_r;
    logic [31:0] data_r;
    logic last_r;
    // Decode and combinational helpers.
    logic wr_en;
    logic rd_setup;
    logic cfg_wr;
    logic dly_wr;
    logic dm11_req;
    logic dm3_req;
    logic dm2_req;
    logic [NDEF-1:0] nz_w;
    logic [NDEF-1:0] rep_w;
    logic [NDEF-1:0] prv_w;
    logic [NDEF-1:0] exp_w;
    logic [NDEF-1:0] clr_w;
    logic [OC_W-1:0] oc_a;
    logic [OC_W-1:0] oc_b;
    logic dm1_go;
    logic dm2_go;
    logic [4:0] dm1_cnt;
    logic [4:0] dm2_cnt;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= OFS_OC);
    endfunction : mapped

    function automatic logic [7:0] lamps(input logic [NDEF-1:0] m);
        lamps = 8'h00;
        for (int k = 0; k < NDEF; k++) begin
            if (m[k]) begin
                lamps = lamps | lamp_byte(lamp_r[k]);
            end
        end
    endfunction : lamps

    // APB decode; zero wait states, error on unmapped addresses.
    assign wr_en = psel && penable && pwrite && mapped(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign cfg_wr = wr_en && (paddr == OFS_CFG);
    assign dly_wr = wr_en && (paddr == OFS_DELAY);
    assign dm11_req = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_DM11_BIT];
    assign dm3_req = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_DM3_BIT];
    assign dm2_req = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_DM2_BIT];

    // Reportable sets and timer expiry per definition.
    always_comb begin
        for (int i = 0; i < NDEF; i++) begin
            nz_w[i] = (spn_r[i] != SPN_RST);
            exp_w[i] = pend_r[i] && fault_in[i] && (tmr_r[i] == '0);
        end
        rep_w = act_r & nz_w;
        prv_w = prev_r & ~act_r & nz_w;
    end
    assign dm1_cnt = popcount(rep_w);
    assign dm2_cnt = popcount(prv_w);

    // OC clears: parameter number change, or DM3 on previous codes.
    always_comb begin
        clr_w = '0;
        if (cfg_wr && (pwdata[SPN_W-1:0] != spn_r[sel_r])) begin
            clr_w = onehot(sel_r);
        end
        if (dm3_req) begin
            clr_w = clr_w | (prev_r & ~act_r);
        end
    end

    jdm_oc_store u_store (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .inc_mask(exp_w),
        .clr_mask(clr_w),
        .rd_a_idx(sel_r),
        .rd_a_data(oc_a),
        .rd_b_idx(scan_r),
        .rd_b_data(oc_b)
    );

    // Configuration registers, written through the selected index.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sel_r <= '0;
            ovr_r <= '0;
            latch_r <= '0;
            for (int i = 0; i < NDEF; i++) begin
                spn_r[i] <= SPN_RST;
                fmi_r[i] <= FMI_RST;
                dfmi_r[i] <= FMI_RST;
                dly_r[i] <= DELAY_RST;
                lamp_r[i] <= LAMP_RST;
            end
        end else begin
            if (wr_en && paddr == OFS_SEL) begin
                sel_r <= pwdata[IDX_W-1:0];
            end
            if (cfg_wr) begin
                spn_r[sel_r] <= pwdata[SPN_W-1:0];
                if (fmi_ok(pwdata[CFG_FMI_LSB+:FMI_W])) begin
                    fmi_r[sel_r] <= pwdata[CFG_FMI_LSB+:FMI_W];
                end
                ovr_r[sel_r] <= pwdata[CFG_OVR_BIT];
                lamp_r[sel_r] <= pwdata[CFG_LAMP_LSB+:2];
                latch_r[sel_r] <= pwdata[CFG_LATCH_BIT];
            end
            if (dly_wr) begin
                dly_r[sel_r] <= pwdata[TMR_W-1:0];
                if (fmi_ok(pwdata[DLY_FMI_LSB+:FMI_W])) begin
                    dfmi_r[sel_r] <= pwdata[DLY_FMI_LSB+:FMI_W];
                end
            end
        end
    end

    // Read data is captured in the setup phase, stable through access.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prdata <= '0;
        end else if (rd_setup) begin
            case (paddr)
                OFS_STATE: prdata <= {prev_r, act_r};
                OFS_INFO: prdata <= {22'h0, st_r != ST_IDLE, up_done_r,
                    3'h0, dm1_cnt};
                OFS_SEL: prdata <= {28'h0, sel_r};
                OFS_CFG: prdata <= {4'h0, latch_r[sel_r], lamp_r[sel_r],
                    ovr_r[sel_r], fmi_r[sel_r], spn_r[sel_r]};
                OFS_DELAY: prdata <= {11'h0, dfmi_r[sel_r], dly_r[sel_r]};
                OFS_OC: prdata <= {25'h0, oc_a};
                default: prdata <= '0;
            endcase
        end
    end

    // Millisecond tick, start-up hold-off and periodic slot.
    assign ms_tick = (ms_cnt_r == CNT_W'(MS_CYC - 1));
    assign rep_tick = up_done_r && (rep_cnt_r == CNT_W'(REPEAT_CYC - 1));
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ms_cnt_r <= '0;
            up_cnt_r <= '0;
            up_done_r <= 1'b0;
            rep_cnt_r <= '0;
        end else begin
            ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
            if (up_cnt_r == CNT_W'(STARTUP_CYC - 1)) begin
                up_done_r <= 1'b1;
            end else begin
                up_cnt_r <= up_cnt_r + 1'b1;
            end
            if (up_done_r) begin
                rep_cnt_r <= rep_tick ? '0 : rep_cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pend_r <= '0;
            act_r <= '0;
            prev_r <= '0;
            for (int i = 0; i < NDEF; i++) begin
                tmr_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NDEF; i++) begin
                if (dm3_req && !act_r[i]) begin
                    prev_r[i] <= 1'b0;
                end
                if (fault_in[i]) begin
                    if (!act_r[i] && !pend_r[i]) begin
                        pend_r[i] <= 1'b1;
                        tmr_r[i] <= dly_r[i];
                    end else if (exp_w[i]) begin
                        pend_r[i] <= 1'b0;
                        act_r[i] <= 1'b1;
                        prev_r[i] <= 1'b0;
                    end else if (pend_r[i] && ms_tick) begin
                        tmr_r[i] <= tmr_r[i] - 16'h0001;
                    end
                end else begin
                    pend_r[i] <= 1'b0;
                    if (act_r[i] && (!latch_r[i] || dm11_req)) begin
                        act_r[i] <= 1'b0;
                        prev_r[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // Message requests; a new event in the start cycle is kept.
    assign dm1_go = (st_r == ST_IDLE) && dm1_pend_r && up_done_r;
    assign dm2_go = (st_r == ST_IDLE) && dm2_pend_r && !dm1_go;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rep_q_r <= '0;
            dm1_pend_r <= 1'b0;
            dm2_pend_r <= 1'b0;
        end else begin
            rep_q_r <= rep_w;
            dm1_pend_r <= (dm1_pend_r && !dm1_go) || rep_tick
                || (|(rep_w & ~rep_q_r))
                || ((rep_q_r != '0) && (rep_w == '0));
            dm2_pend_r <= (dm2_pend_r && !dm2_go) || dm2_req;
        end
    end

    // Sender: header beat, then one beat per listed trouble code.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r <= ST_IDLE;
            list_r <= '0;
            scan_r <= '0;
            kind_r <= KIND_DM1;
            multi_r <= 1'b0;
            data_r <= '0;
            last_r <= 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    scan_r <= '0;
                    if (dm1_go || dm2_go) begin
                        list_r <= dm1_go ? rep_w : prv_w;
                        kind_r <= dm1_go ? KIND_DM1 : KIND_DM2;
                        multi_r <= (dm1_go ? dm1_cnt : dm2_cnt) > 5'h01;
                        data_r <= {8'h00, 3'h0,
                            dm1_go ? dm1_cnt : dm2_cnt, FLASH_OFF,
                            lamps(dm1_go ? rep_w : prv_w)};
                        last_r <= (dm1_go ? rep_w : prv_w) == '0;
                        st_r <= ST_HEAD;
                    end
                end
                ST_HEAD: begin
                    if (tx_ready) begin
                        st_r <= last_r ? ST_IDLE : ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (list_r[scan_r]) begin
                        st_r <= ST_LOAD;
                    end else begin
                        scan_r <= scan_r + 4'h1;
                    end
                end
                ST_LOAD: begin
                    data_r <= make_dtc(spn_r[scan_r],
                        ovr_r[scan_r] ? fmi_r[scan_r] : dfmi_r[scan_r],
                        oc_b);
                    list_r <= list_r & ~onehot(scan_r);
                    last_r <= (list_r & ~onehot(scan_r)) == '0;
                    st_r <= ST_SEND;
                end
                ST_SEND: begin
                    if (tx_ready) begin
                        scan_r <= scan_r + 4'h1;
                        st_r <= last_r ? ST_IDLE : ST_FETCH;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Stream outputs; valid is a decode of the registered state.
    assign tx_valid = (st_r == ST_HEAD) || (st_r == ST_SEND);
    assign tx_first = (st_r == ST_HEAD);
    assign tx_last = last_r;
    assign tx_kind = kind_r;
    assign tx_multi = multi_r;
    assign tx_data = data_r;
endmodule : jdm_dtc_manager

//--- jdm_dtc_checker_assertions.sv
// Port checker for the trouble-code manager.
// Assumes the top module's ports only; attached by the bind below.
module jdm_dtc_checker #(
    parameter int unsigned STARTUP_CYC = 50
)
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // APB.
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Stream.
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic tx_first,
    input wire logic tx_last,
    input wire logic tx_multi,
    input wire logic [31:0] tx_data
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    int unsigned cnt_r;
    logic mapped;
    logic hdr;
    logic beat;
    // Cycles since reset; saturates so it never wraps back into hold-off.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_r <= 0;
        end else if (cnt_r < STARTUP_CYC) begin
            cnt_r <= cnt_r + 1;
        end
    end
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h18);
    assign hdr = tx_valid && tx_first;
    assign beat = tx_valid && !tx_first;
    a_startup_quiet: assert property (
        cnt_r < STARTUP_CYC |-> !tx_valid)
        else $error("stream beat during start-up hold-off");
    a_beat_holds: assert property (
        tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data) && $stable(tx_first))
        else $error("unaccepted beat changed");
    a_multi_count: assert property (
        hdr |-> tx_multi == (tx_data[20:16] > 5'h01))
        else $error("multipacket flag disagrees with code count");
    a_nofault_single: assert property (
        hdr && tx_data[20:16] == 5'h00 |-> tx_last)
        else $error("no-fault message not header only");
    a_method_zero: assert property (
        beat |-> tx_data[31] == 1'b0)
        else $error("conversion method bit set");
    a_fmi_legal: assert property (
        beat |-> tx_data[20:16] <= 5'h15 || tx_data[20:16] == 5'h1f)
        else $error("illegal failure mode sent");
    a_spn_nonzero: assert property (
        beat |-> {tx_data[23:21], tx_data[15:0]} != 19'h00000)
        else $error("code with zero parameter number sent");
    a_unmapped_err: assert property (
        psel && penable |-> pready && (pslverr == !mapped))
        else $error("slave error does not match address map");
    c_multi: cover property (hdr && tx_multi);
    c_stall: cover property (tx_valid && !tx_ready);
    c_err: cover property (psel && penable && pslverr);
endmodule : jdm_dtc_checker

bind jdm_dtc_manager jdm_dtc_checker #(.STARTUP_CYC(STARTUP_CYC)) u_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_first(tx_first),
    .tx_last(tx_last), .tx_multi(tx_multi), .tx_data(tx_data));

//--- jdm_can_peer.sv
// Transport-side sink that drains the message stream with random stalls.
// Assumes the stream handshake of the manager on one clock.
module jdm_can_peer (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Stream from the manager.
    input wire logic tx_valid,
    input wire logic tx_first,
    input wire logic tx_multi,
    input wire logic [31:0] tx_data,
    input wire logic [1:0] tx_kind,
    output logic tx_ready,
    // Last header, last code and message count seen.
    output logic [31:0] hdr_w,
    output logic [31:0] code_w,
    output logic multi_w,
    output logic [1:0] kind_w,
    output int n_msg
);
    timeunit 1ns;
    timeprecision 1ns;
    // Stalls one cycle in four so held beats are exercised.
    // The message count restarts with reset, so it has a single driver.
    always_ff @(posedge ref_clk) begin
        tx_ready <= !sys_rst && ($urandom % 4 != 0);
        if (sys_rst) begin
            n_msg <= 0;
        end else if (tx_valid && tx_ready && tx_first) begin
            hdr_w <= tx_data;
            multi_w <= tx_multi;
            kind_w <= tx_kind;
            n_msg <= n_msg + 1;
        end else if (tx_valid && tx_ready) begin
            code_w <= tx_data;
        end
    end
endmodule : jdm_can_peer

//--- tb_top.sv
// Self-checking bench of the trouble-code manager.
// Assumes shortened timing parameters and the sink model beside it.
module tb_top;
    import jdm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, hdr_w, code_w, rd, tx_data;
    logic pready, pslverr, tx_valid, tx_ready, tx_first, tx_last;
    logic tx_multi, multi_w, er;
    logic [1:0] tx_kind, kind_w;
    logic [NDEF-1:0] fault_in = 16'h0000;
    int n_msg, n_errors = 0, checks_done = 0, cyc = 0;
    int spn_a, spn_b;
    always #50 ref_clk = !ref_clk;
    jdm_dtc_manager #(.MS_CYC(4), .STARTUP_CYC(50), .REPEAT_CYC(200)) dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault_in(fault_in), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_first(tx_first), .tx_last(tx_last), .tx_kind(tx_kind),
        .tx_multi(tx_multi), .tx_data(tx_data));
    jdm_can_peer peer (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .tx_valid(tx_valid), .tx_first(tx_first), .tx_multi(tx_multi),
        .tx_data(tx_data), .tx_kind(tx_kind), .tx_ready(tx_ready),
        .hdr_w(hdr_w), .code_w(code_w), .multi_w(multi_w),
        .kind_w(kind_w), .n_msg(n_msg));
    task automatic close_out();
        if (n_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer; request held until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    // Waits k message starts; a message that never comes is a mismatch.
    task automatic wait_msg(input int k);
        int m;
        m = n_msg;
        for (int i = 0; i < 1000 && n_msg < m + k; i++) @(posedge ref_clk);
        if (n_msg < m + k) begin
            n_errors++;
        end
    endtask : wait_msg
    // Model of a trouble code built from parameter, mode and count.
    function automatic logic [31:0] code(int spn, int fmi, int oc);
        return {1'b0, oc[6:0], spn[18:16], fmi[4:0], spn[15:0]};
    endfunction : code
    // Hang guard; the whole run needs about two thousand cycles.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        void'($urandom(77));
        repeat (8) @(posedge ref_clk);
        sys_rst <= 0;
        apb(1, OFS_SEL, 32'h2);
        apb(0, OFS_CFG, 0);
        chk(rd, 32'h02f80000);
        apb(0, OFS_DELAY, 0);
        chk(rd & 32'hffff, 32'h64);
        apb(0, 8'h40, 0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        spn_a = 1 + $urandom % 32'h7fffe;
        spn_b = 1 + $urandom % 32'h7fffe;
        // Low-side mode 5 here, its high-side 6 on the second code.
        apb(1, OFS_CFG, 32'h05000000 | 32'h01280000 | spn_a);
        apb(1, OFS_DELAY, 32'h2);
        fault_in[2] <= 1;
        repeat (4) @(posedge ref_clk);
        fault_in[2] <= 0;
        repeat (20) @(posedge ref_clk);
        apb(0, OFS_STATE, 0);
        chk(rd, 32'h0);
        fault_in[2] <= 1;
        repeat (20) @(posedge ref_clk);
        apb(0, OFS_STATE, 0);
        chk(rd, 32'h4);
        apb(0, OFS_OC, 0);
        chk(rd & 32'h7f, 32'h1);
        wait_msg(2);
        chk(hdr_w, {11'h0, 5'h1, 8'hff, 8'h10});
        chk({kind_w, multi_w}, {KIND_DM1, 1'b0});
        chk(code_w, code(spn_a, 5, 1));
        apb(1, OFS_SEL, 32'h5);
        apb(1, OFS_CFG, 32'h0b300000 | spn_b);
        apb(1, OFS_DELAY, 32'h0);
        fault_in[5] <= 1;
        wait_msg(3);
        chk({hdr_w[20:16], hdr_w[7:0], multi_w}, {5'h2, 8'h14, 1'b1});
        chk(code_w, code(spn_b, 6, 1));
        fault_in <= 16'h0000;
        repeat (30) @(posedge ref_clk);
        apb(0, OFS_STATE, 0);
        chk(rd, 32'h00040020);
        apb(1, OFS_CTRL, 32'h1);
        apb(0, OFS_STATE, 0);
        chk(rd, 32'h00240000);
        wait_msg(2);
        chk(hdr_w[20:16], 5'h0);
        apb(1, OFS_CTRL, 32'h4);
        for (int i = 0; i < 1000 && kind_w !== KIND_DM2; i++) @(posedge ref_clk);
        chk({kind_w, hdr_w[20:16], hdr_w[7:0]}, {KIND_DM2, 5'h2, 8'h14});
        apb(1, OFS_CTRL, 32'h2);
        apb(1, OFS_SEL, 32'h2);
        apb(0, OFS_STATE, 0);
        chk(rd, 32'h0);
        apb(0, OFS_OC, 0);
        chk(rd & 32'h7f, 32'h0);
        apb(1, OFS_SEL, 32'h7);
        apb(1, OFS_DELAY, 32'h00110000);
        fault_in[7] <= 1;
        wait_msg(2);
        chk(hdr_w[20:16], 5'h0);
        apb(0, OFS_STATE, 0);
        chk(rd, 32'h80);
        apb(0, OFS_INFO, 0);
        chk(rd & 32'h1ff, 32'h100);
        // Re-arm code 7 with a number and no override: default mode 17.
        fault_in[7] <= 0;
        apb(1, OFS_CFG, spn_a);
        fault_in[7] <= 1;
        wait_msg(3);
        chk(code_w, code(spn_a, 17, 1));
        // A reset in mid-run must leave the occurrence counts alone.
        sys_rst <= 1;
        fault_in <= 16'h0000;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 0;
        apb(1, OFS_SEL, 32'h7);
        apb(0, OFS_OC, 0);
        chk(rd & 32'h7f, 32'h1);
        close_out();
    end
endmodule : tb_top
